// ===== design/cpp_params.svh
// Purpose: constants of the control panel parallel port
// Assumes: 20 MHz mclk_i
// Notes: offsets, reset values and timing counts
`ifndef CPP_PARAMS_SVH
`define CPP_PARAMS_SVH

`define CPP_CLK_NS 50
// least width of a read or write strobe
`define CPP_STROBE_NS 300
`define CPP_STROBE_CYC \
   ((`CPP_STROBE_NS + `CPP_CLK_NS - 1) / `CPP_CLK_NS)

// control word fields
`define CPP_CW_MODESET_BIT 7
`define CPP_CW_A_IN_BIT 4
`define CPP_CW_CHI_IN_BIT 3
`define CPP_CW_B_IN_BIT 1
`define CPP_CW_CLO_IN_BIT 0
// all groups input, mode 0
`define CPP_CW_RESET 8'h9b
// switch port and split low in, indicator and split high out
`define CPP_CW_PANEL 8'h91
`define CPP_LATCH_RESET 8'h00
`define CPP_CTRL_READ 8'hff

// host register offsets
`define CPP_OFF_CMD 8'h00
`define CPP_OFF_STATUS 8'h04
`define CPP_OFF_SWITCH 8'h08
`define CPP_OFF_ERRMASK 8'h0c
`define CPP_ERRMASK_RESET 12'hfff
// command and status word fields
`define CPP_CMD_OP_LSB 8
`define CPP_CMD_OP_MSB 9
`define CPP_STAT_BUSY_BIT 0
`define CPP_STAT_INIT_BIT 1

`endif

// ===== design/cpp_pkg.sv
// Purpose: types shared by both ends of the panel port
// Assumes: nothing
// Notes: select encodings follow the register select lines
package cpp_pkg;
   typedef enum logic [1:0] {
      SEL_SWITCH = 2'b00,
      SEL_INDICATOR = 2'b01,
      SEL_SPLIT = 2'b10,
      SEL_CONTROL = 2'b11
   } cpp_sel_e;
   typedef enum logic [1:0] {
      OP_WR_IND = 2'b00,
      OP_WR_SPLIT = 2'b01,
      OP_RD_SW = 2'b10,
      OP_WR_CTRL = 2'b11
   } cpp_op_e;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SETUP = 2'b01,
      ST_STROBE = 2'b10,
      ST_RELEASE = 2'b11
   } cpp_state_e;
   typedef logic [7:0] cpp_byte_t;
endpackage

// ===== design/cpp_panel_if.sv
// Purpose: microprocessor side bus of the panel port
// Assumes: both ends on mclk_i
// Notes: bus floats high when nobody drives it
`timescale 1ns/1ns
`default_nettype none
interface cpp_panel_if;
   logic cs_n;
   logic rd_n;
   logic wr_n;
   logic [1:0] sel;
   logic [7:0] host_data;
   logic host_oe_n;
   logic [7:0] dev_data;
   logic dev_oe_n;
   logic [7:0] data;
   assign data = !dev_oe_n ? dev_data :
                 (!host_oe_n ? host_data : 8'hff);
   modport dev (input cs_n, rd_n, wr_n, sel, data,
                output dev_data, dev_oe_n);
   modport host (output cs_n, rd_n, wr_n, sel, host_data, host_oe_n,
                 input data);
endinterface
`default_nettype wire

// ===== design/cpp_line_group.sv
// Purpose: one group of port lines, latch plus direction
// Assumes: pad level resolved outside, pull-ups included
// Notes: read value is the pad when input, the latch when output
`timescale 1ns/1ns
`default_nettype none
module cpp_line_group #(
   parameter int W = 8
) (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   input wire logic dir_in_i,
   input wire logic wr_i,
   input wire logic [W-1:0] wr_data_i,
   input wire logic [W-1:0] pad_i,
   output logic [W-1:0] pad_o,
   output logic [W-1:0] pad_oe_n_o,
   output logic [W-1:0] rd_o
);
   logic [W-1:0] latch_q;
   logic [W-1:0] oe_n_q;
   logic [W-1:0] samp_q;

   if (W < 1 || W > 8) begin : g_chk
      $error("line group width must be 1 to 8");
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         latch_q <= '0;
         oe_n_q <= '1;
         samp_q <= '1;
      end else if (ce_i) begin
         if (wr_i) begin
            latch_q <= wr_data_i;
         end
         oe_n_q <= {W{dir_in_i}};
         samp_q <= pad_i;
      end
   end

   assign pad_o = latch_q;
   assign pad_oe_n_o = oe_n_q;
   // open switch: pull-up, reads one; closed: grounded, reads zero
   assign rd_o = dir_in_i ? samp_q : latch_q;
endmodule
`default_nettype wire

// ===== design/cpp_port_dev.sv
// Purpose: panel end, eight-bit parallel port in simple I/O mode
// Assumes: strobes and pads synchronous to mclk_i
// Notes: writes commit at the trailing edge of the write strobe
`timescale 1ns/1ns
`default_nettype none
`include "cpp_params.svh"

module cpp_port_dev (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   cpp_panel_if.dev bus,
   input wire logic [7:0] switch_port_lines_i,
   output logic [7:0] switch_port_lines_o,
   output logic [7:0] switch_port_lines_oe_n_o,
   input wire logic [7:0] indicator_port_lines_i,
   output logic [7:0] indicator_port_lines_o,
   output logic [7:0] indicator_port_lines_oe_n_o,
   input wire logic [3:0] split_port_low_inputs_i,
   output logic [3:0] split_port_low_inputs_o,
   output logic [3:0] split_port_low_inputs_oe_n_o,
   input wire logic [3:0] split_port_high_outputs_i,
   output logic [3:0] split_port_high_outputs_o,
   output logic [3:0] split_port_high_outputs_oe_n_o,
   output logic [7:0] control_word_o
);
   import cpp_pkg::*;

   logic [7:0] ctrl_q;
   logic [7:0] ctrl_d;
   logic [7:0] rdata_q;
   logic rd_oe_n_q;
   logic wr_act_q;
   logic [7:0] wcap_q;
   cpp_sel_e wsel_q;

   // strobes are levels; read data is a flop one cycle behind rd
   wire rd_act = !bus.cs_n && !bus.rd_n;
   wire wr_act = !bus.cs_n && !bus.wr_n;
   // commit once the strobe ends, after the bus data was captured
   wire commit = wr_act_q && !wr_act;
   cpp_sel_e rsel;
   assign rsel = cpp_sel_e'(bus.sel);

   // one write target hit at the commit edge
   function automatic logic wr_hit(input logic cm, input cpp_sel_e s,
                                   input cpp_sel_e want);
      return cm && s == want;
   endfunction

   // decoded write enables at the trailing edge of the strobe
   wire wr_a = wr_hit(commit, wsel_q, SEL_SWITCH);
   wire wr_b = wr_hit(commit, wsel_q, SEL_INDICATOR);
   wire wr_c = wr_hit(commit, wsel_q, SEL_SPLIT);
   wire wr_cw = wr_hit(commit, wsel_q, SEL_CONTROL);
   wire modeset = wr_cw && wcap_q[`CPP_CW_MODESET_BIT];
   wire bitset = wr_cw && !wcap_q[`CPP_CW_MODESET_BIT];

   // bit set/reset of one split port bit
   function automatic logic [7:0] set_bit(input logic [7:0] cur,
                                          input logic [7:0] cw);
      logic [7:0] r;
      r = cur;
      r[cw[3:1]] = cw[0];
      return r;
   endfunction

   // direction bits of the stored control word, one means input
   wire a_in = ctrl_q[`CPP_CW_A_IN_BIT];
   wire b_in = ctrl_q[`CPP_CW_B_IN_BIT];
   wire clo_in = ctrl_q[`CPP_CW_CLO_IN_BIT];
   wire chi_in = ctrl_q[`CPP_CW_CHI_IN_BIT];

   logic [7:0] a_rd;
   logic [7:0] b_rd;
   logic [3:0] clo_rd;
   logic [3:0] chi_rd;
   logic [7:0] a_pad;
   logic [7:0] a_oe;
   logic [7:0] b_pad;
   logic [7:0] b_oe;
   logic [3:0] clo_pad;
   logic [3:0] clo_oe;
   logic [3:0] chi_pad;
   logic [3:0] chi_oe;

   // split port after a bit set/reset or a full write
   wire [7:0] c_cur = {chi_rd, clo_rd};
   wire [7:0] c_new = bitset ? set_bit(c_cur, wcap_q) : wcap_q;
   wire c_wr = wr_c || bitset || modeset;
   // a mode set clears every output latch
   wire [7:0] c_val = modeset ? `CPP_LATCH_RESET : c_new;
   wire [7:0] ab_val = modeset ? `CPP_LATCH_RESET : wcap_q;

   cpp_line_group #(.W(8)) u_grp_a (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(ce_i),
      .dir_in_i(a_in),
      .wr_i(wr_a || modeset),
      .wr_data_i(ab_val),
      .pad_i(switch_port_lines_i),
      .pad_o(a_pad),
      .pad_oe_n_o(a_oe),
      .rd_o(a_rd)
   );

   cpp_line_group #(.W(8)) u_grp_b (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(ce_i),
      .dir_in_i(b_in),
      .wr_i(wr_b || modeset),
      .wr_data_i(ab_val),
      .pad_i(indicator_port_lines_i),
      .pad_o(b_pad),
      .pad_oe_n_o(b_oe),
      .rd_o(b_rd)
   );

   cpp_line_group #(.W(4)) u_grp_clo (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(ce_i),
      .dir_in_i(clo_in),
      .wr_i(c_wr),
      .wr_data_i(c_val[3:0]),
      .pad_i(split_port_low_inputs_i),
      .pad_o(clo_pad),
      .pad_oe_n_o(clo_oe),
      .rd_o(clo_rd)
   );

   cpp_line_group #(.W(4)) u_grp_chi (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(ce_i),
      .dir_in_i(chi_in),
      .wr_i(c_wr),
      .wr_data_i(c_val[7:4]),
      .pad_i(split_port_high_outputs_i),
      .pad_o(chi_pad),
      .pad_oe_n_o(chi_oe),
      .rd_o(chi_rd)
   );

   // pads come from the group flops unchanged
   assign switch_port_lines_o = a_pad;
   assign switch_port_lines_oe_n_o = a_oe;
   assign indicator_port_lines_o = b_pad;
   assign indicator_port_lines_oe_n_o = b_oe;
   assign split_port_low_inputs_o = clo_pad;
   assign split_port_low_inputs_oe_n_o = clo_oe;
   assign split_port_high_outputs_o = chi_pad;
   assign split_port_high_outputs_oe_n_o = chi_oe;

   // mode bits are stored but only the simple mode is served
   assign ctrl_d = modeset ? wcap_q : ctrl_q;

   // the control address reads back as all ones
   wire [7:0] rmux = (rsel == SEL_SWITCH) ? a_rd :
                     (rsel == SEL_INDICATOR) ? b_rd :
                     (rsel == SEL_SPLIT) ? c_cur :
                     `CPP_CTRL_READ;

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         // every group an input until the host sets the mode
         ctrl_q <= `CPP_CW_RESET;
         rdata_q <= '0;
         rd_oe_n_q <= 1'b1;
         wr_act_q <= 1'b0;
         wcap_q <= '0;
         wsel_q <= SEL_SWITCH;
      end else if (ce_i) begin
         ctrl_q <= ctrl_d;
         rdata_q <= rmux;
         rd_oe_n_q <= !rd_act;
         wr_act_q <= wr_act;
         // hold the last data and select seen while the strobe was low
         if (wr_act) begin
            wcap_q <= bus.data;
            wsel_q <= rsel;
         end
      end
   end

   // the bus is driven only a cycle after a read strobe is seen
   assign bus.dev_data = rdata_q;
   assign bus.dev_oe_n = rd_oe_n_q;
   assign control_word_o = ctrl_q;
endmodule
`default_nettype wire

// ===== design/cpp_port_host.sv
// Purpose: processor end, drives panel port from APB orders
// Assumes: APB on mclk_i, device answers a read one cycle in
// Notes: orders arriving while busy are ignored
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "cpp_params.svh"
module cpp_port_host #(
   parameter int STROBE_CYC = `CPP_STROBE_CYC
) (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic reset_key_i,
   cpp_panel_if.host bus
);
   import cpp_pkg::*;

   if (STROBE_CYC < 2 || STROBE_CYC > 255) begin : g_chk
      $error("strobe must be 2 to 255 cycles");
   end

   cpp_state_e st_q;
   logic [7:0] cnt_q;
   cpp_sel_e sel_q;
   logic wr_q, cs_n_q, rd_n_q, wr_n_q, oe_n_q;
   logic [7:0] dout_q;
   logic init_q, done_q, rdc_q, cmd_q;
   logic [1:0] key_q;
   cpp_op_e op_q;
   logic [7:0] arg_q, ind_q;
   logic [3:0] hi_q;
   logic [11:0] mask_q, sw_q;
   logic rdy_q, err_q;
   logic [31:0] prd_q;

   wire idle = st_q == ST_IDLE;
   wire busy = !idle || init_q || rdc_q || cmd_q || key_q != 2'b00;
   wire acc = psel_i && penable_i && !rdy_q;
   wire take_w = psel_i && penable_i && rdy_q && pwrite_i;
   wire a_cmd = paddr_i == `CPP_OFF_CMD;
   wire a_st = paddr_i == `CPP_OFF_STATUS;
   wire a_sw = paddr_i == `CPP_OFF_SWITCH;
   wire a_mk = paddr_i == `CPP_OFF_ERRMASK;
   wire hit = a_cmd || a_st || a_sw || a_mk;
   wire new_cmd = take_w && a_cmd && !busy;
   wire last = st_q == ST_STROBE && cnt_q == 8'(STROBE_CYC - 1);
   // error indicators turned off, other lamps kept
   wire [7:0] ind_clr = ind_q & ~mask_q[7:0];
   wire [3:0] hi_clr = hi_q & ~mask_q[11:8];

   wire [31:0] rmux = a_st ? {30'h0, done_q, busy} :
                      a_sw ? {20'h0, sw_q} :
                      a_mk ? {20'h0, mask_q} : 32'h0;

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         rdy_q <= 1'b0;
         err_q <= 1'b0;
         prd_q <= '0;
         mask_q <= `CPP_ERRMASK_RESET;
      end else if (ce_i) begin
         rdy_q <= acc;
         err_q <= acc && !hit;
         prd_q <= acc && !pwrite_i ? rmux : 32'h0;
         if (take_w && a_mk) begin
            mask_q <= pwdata_i[11:0];
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         st_q <= ST_IDLE;
         cnt_q <= '0;
         sel_q <= SEL_SWITCH;
         wr_q <= 1'b0;
         cs_n_q <= 1'b1;
         rd_n_q <= 1'b1;
         wr_n_q <= 1'b1;
         oe_n_q <= 1'b1;
         dout_q <= '0;
         init_q <= 1'b1;
         done_q <= 1'b0;
         rdc_q <= 1'b0;
         cmd_q <= 1'b0;
         key_q <= 2'b00;
         op_q <= OP_WR_IND;
         arg_q <= '0;
         ind_q <= '0;
         hi_q <= '0;
         sw_q <= '0;
      end else if (ce_i) begin
         if (new_cmd) begin
            cmd_q <= 1'b1;
            op_q <= cpp_op_e'(pwdata_i[`CPP_CMD_OP_MSB:`CPP_CMD_OP_LSB]);
            arg_q <= pwdata_i[7:0];
         end
         if (reset_key_i) begin
            key_q <= 2'b11;
         end
         case (st_q)
            ST_IDLE: begin
               if (init_q) begin
                  init_q <= 1'b0;
                  sel_q <= SEL_CONTROL;
                  wr_q <= 1'b1;
                  dout_q <= `CPP_CW_PANEL;
                  st_q <= ST_SETUP;
               end else if (rdc_q) begin
                  rdc_q <= 1'b0;
                  sel_q <= SEL_SPLIT;
                  wr_q <= 1'b0;
                  st_q <= ST_SETUP;
               end else if (key_q[0]) begin
                  key_q[0] <= reset_key_i;
                  sel_q <= SEL_INDICATOR;
                  wr_q <= 1'b1;
                  dout_q <= ind_clr;
                  ind_q <= ind_clr;
                  st_q <= ST_SETUP;
               end else if (key_q[1]) begin
                  key_q[1] <= reset_key_i;
                  sel_q <= SEL_SPLIT;
                  wr_q <= 1'b1;
                  dout_q <= {hi_clr, 4'h0};
                  hi_q <= hi_clr;
                  st_q <= ST_SETUP;
               end else if (cmd_q && !new_cmd) begin
                  cmd_q <= 1'b0;
                  wr_q <= op_q != OP_RD_SW;
                  dout_q <= arg_q;
                  st_q <= ST_SETUP;
                  case (op_q)
                     OP_WR_IND: begin
                        sel_q <= SEL_INDICATOR;
                        ind_q <= arg_q;
                     end
                     OP_WR_SPLIT: begin
                        sel_q <= SEL_SPLIT;
                        hi_q <= arg_q[7:4];
                     end
                     OP_RD_SW: begin
                        sel_q <= SEL_SWITCH;
                        rdc_q <= 1'b1;
                     end
                     default: sel_q <= SEL_CONTROL;
                  endcase
               end
            end
            ST_SETUP: begin
               cs_n_q <= 1'b0;
               oe_n_q <= !wr_q;
               cnt_q <= '0;
               st_q <= ST_STROBE;
            end
            ST_STROBE: begin
               rd_n_q <= wr_q;
               wr_n_q <= !wr_q;
               cnt_q <= cnt_q + 8'h01;
               if (last) begin
                  st_q <= ST_RELEASE;
                  if (!wr_q && sel_q == SEL_SWITCH) begin
                     sw_q[7:0] <= ~bus.data;
                  end
                  if (!wr_q && sel_q == SEL_SPLIT) begin
                     sw_q[11:8] <= ~bus.data[3:0];
                  end
               end
            end
            ST_RELEASE: begin
               rd_n_q <= 1'b1;
               wr_n_q <= 1'b1;
               cs_n_q <= 1'b1;
               oe_n_q <= 1'b1;
               done_q <= 1'b1;
               st_q <= ST_IDLE;
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   assign prdata_o = prd_q;
   assign pready_o = rdy_q;
   assign pslverr_o = err_q;
   assign bus.cs_n = cs_n_q;
   assign bus.rd_n = rd_n_q;
   assign bus.wr_n = wr_n_q;
   assign bus.sel = sel_q;
   assign bus.host_data = dout_q;
   assign bus.host_oe_n = oe_n_q;
endmodule
`default_nettype wire

// ===== verif/cpp_panel_chk.sv
// Purpose: checks on the panel bus between host and device ends
// Assumes: one clock mclk_i, synchronous high reset
// Notes: watches the interface signals only
`timescale 1ns/1ns
`default_nettype none
`include "cpp_params.svh"
module cpp_panel_chk
import cpp_pkg::*;
#(
   parameter int STROBE_CYC = `CPP_STROBE_CYC
) (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [1:0] sel,
   input wire logic [7:0] host_data,
   input wire logic host_oe_n,
   input wire logic [7:0] dev_data,
   input wire logic dev_oe_n,
   input wire logic [7:0] data
);
   logic [7:0] stb_q;
   logic first_q;
   // counts cycles of the current strobe
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i || (rd_n && wr_n)) begin
         stb_q <= 8'h00;
      end else begin
         stb_q <= stb_q + 8'h01;
      end
   end
   // high until the first write after reset completes
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         first_q <= 1'b1;
      end else if ($rose(wr_n)) begin
         first_q <= 1'b0;
      end
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   a_reset_quiet: assert property (disable iff (1'b0) sys_rst_i |=>
      (dev_oe_n && cs_n && rd_n && wr_n)) else $error("bus busy after reset");
   a_read_drive: assert property (!cs_n && !rd_n |=> !dev_oe_n)
      else $error("device not driving during read");
   a_read_release: assert property ($rose(rd_n) |-> ##[1:2] dev_oe_n)
      else $error("device holds bus after read");
   a_write_quiet: assert property (!wr_n |-> dev_oe_n && !host_oe_n)
      else $error("bus owner wrong during write");
   a_strobe_cs: assert property ((!rd_n || !wr_n) |-> !cs_n &&
      (rd_n || wr_n)) else $error("strobe without select or both strobes");
   a_strobe_width: assert property ($rose(rd_n) || $rose(wr_n) |->
      stb_q == STROBE_CYC) else $error("strobe width wrong");
   a_sel_steady: assert property (!cs_n && $past(!cs_n) |->
      $stable(sel)) else $error("select changed inside cycle");
   a_idle_gap: assert property ($rose(cs_n) |=> cs_n)
      else $error("no idle cycle between transfers");
   a_first_cword: assert property ($fell(wr_n) && first_q |->
      sel == SEL_CONTROL && data == `CPP_CW_PANEL)
      else $error("first write is not the panel control word");
   a_write_data: assert property (!wr_n |-> data == host_data)
      else $error("bus data differs from host data during write");
   a_read_data: assert property (!dev_oe_n |-> data == dev_data)
      else $error("bus data differs from device data during read");
endmodule
`default_nettype wire

// ===== verif/control_panel_parallel_port_tb.sv
// Purpose: drives the host end over APB, watches the device end pins
// Assumes: switches pulled up, closed switch grounds its line
// Notes: scenario tasks each judge their own results
`timescale 1ns/1ns
`default_nettype none
`include "cpp_params.svh"
module control_panel_parallel_port_tb;
import cpp_pkg::*;
   localparam int SC = 6;
   logic mclk_i = 1'b0, sys_rst_i = 1'b1, reset_key_i = 1'b0;
   logic ce = 1'b1;
   logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0, prdata_o;
   logic pready_o, pslverr_o;
   logic [7:0] sw_lvl = 8'hff, sw_o, sw_oe_n, ind_o, ind_oe_n, cw;
   logic [3:0] lo_lvl = 4'hf, lo_o, lo_oe_n, hi_o, hi_oe_n;
   int fail_count = 0, cmp_count = 0;
   cpp_panel_if pif();
   cpp_port_dev cpp_port_dev_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
      .ce_i(ce), .bus(pif), .switch_port_lines_i(sw_lvl & (sw_o | sw_oe_n)),
      .switch_port_lines_o(sw_o), .switch_port_lines_oe_n_o(sw_oe_n),
      .indicator_port_lines_i(ind_o | ind_oe_n),
      .indicator_port_lines_o(ind_o), .indicator_port_lines_oe_n_o(ind_oe_n),
      .split_port_low_inputs_i(lo_lvl & (lo_o | lo_oe_n)),
      .split_port_low_inputs_o(lo_o), .split_port_low_inputs_oe_n_o(lo_oe_n),
      .split_port_high_outputs_i(hi_o | hi_oe_n),
      .split_port_high_outputs_o(hi_o),
      .split_port_high_outputs_oe_n_o(hi_oe_n), .control_word_o(cw));
   cpp_port_host #(.STROBE_CYC(SC)) cpp_port_host_i (.mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i), .ce_i(ce), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .reset_key_i(reset_key_i), .bus(pif));
   cpp_panel_chk #(.STROBE_CYC(SC)) cpp_panel_chk_i (.mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i), .cs_n(pif.cs_n), .rd_n(pif.rd_n),
      .wr_n(pif.wr_n), .sel(pif.sel), .host_data(pif.host_data),
      .host_oe_n(pif.host_oe_n), .dev_data(pif.dev_data),
      .dev_oe_n(pif.dev_oe_n), .data(pif.data));
   initial begin
      forever #25 mclk_i = ~mclk_i;
   end
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
      int n;
      @(posedge mclk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= wd;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 50);
      if (pready_o !== 1'b1) begin
         fail_count++;
         wrap_up();
      end
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic wait_idle;
      logic [31:0] r;
      logic e;
      int n;
      n = 0;
      do begin
         apb(1'b0, `CPP_OFF_STATUS, 32'h0, r, e);
         n++;
      end while ((r[0] !== 1'b0 || r[1] !== 1'b1) && n < 100);
      if (r[0] !== 1'b0 || r[1] !== 1'b1) begin
         fail_count++;
         wrap_up();
      end
   endtask
   task automatic cmd(input cpp_op_e op, input cpp_byte_t arg);
      wr(`CPP_OFF_CMD, {22'h0, op, arg});
      wait_idle();
   endtask
   task automatic t_reset;
      repeat (3) @(posedge mclk_i);
      check("reset control", 32'(cw), 32'h9b);
      check("reset dirs", {8'h0, sw_oe_n, ind_oe_n, lo_oe_n, hi_oe_n},
            32'hffffff);
      sys_rst_i <= 1'b0;
   endtask
   task automatic t_init;
      logic [31:0] r;
      logic e;
      wait_idle();
      // group directions follow the control word one cycle later
      repeat (2) @(posedge mclk_i);
      check("panel control", 32'(cw), 32'h91);
      check("input dirs", 32'({sw_oe_n, lo_oe_n}), 32'hfff);
      check("output dirs", 32'({ind_oe_n, hi_oe_n}), 32'h0);
      apb(1'b0, `CPP_OFF_ERRMASK, 32'h0, r, e);
      check("errmask reset", r, 32'hfff);
   endtask
   task automatic t_outputs;
      cmd(OP_WR_IND, 8'ha5);
      check("indicator", 32'(ind_o), 32'ha5);
      cmd(OP_WR_SPLIT, 8'h3c);
      check("split high", 32'(hi_o), 32'h3);
      check("indicator kept", 32'(ind_o), 32'ha5);
      // bit set of split bit 7 through the control address
      cmd(OP_WR_CTRL, 8'h0f);
      check("split bit set", 32'(hi_o), 32'hb);
   endtask
   task automatic t_switches;
      logic [31:0] r;
      logic e;
      logic [11:0] pat [3] = '{12'h65a, 12'hfff, 12'h000};
      for (int i = 0; i < 3; i++) begin
         @(posedge mclk_i);
         {lo_lvl, sw_lvl} <= pat[i];
         cmd(OP_RD_SW, 8'h00);
         apb(1'b0, `CPP_OFF_SWITCH, 32'h0, r, e);
         check("switches", r, {20'h0, ~pat[i]});
      end
   endtask
   task automatic t_refuse;
      wr(`CPP_OFF_CMD, {22'h0, OP_WR_IND, 8'h11});
      wr(`CPP_OFF_CMD, {22'h0, OP_WR_IND, 8'h22});
      wait_idle();
      check("busy refusal", 32'(ind_o), 32'h11);
   endtask
   task automatic t_freeze;
      wr(`CPP_OFF_CMD, {22'h0, OP_WR_IND, 8'h5a});
      ce <= 1'b0;
      repeat (20) @(posedge mclk_i);
      check("frozen indicator", 32'(ind_o), 32'h11);
      check("frozen control", 32'(cw), 32'h91);
      ce <= 1'b1;
      wait_idle();
      check("thawed indicator", 32'(ind_o), 32'h5a);
   endtask
   task automatic t_key;
      wr(`CPP_OFF_ERRMASK, 32'h30f);
      cmd(OP_WR_IND, 8'hff);
      cmd(OP_WR_SPLIT, 8'hf0);
      @(posedge mclk_i);
      reset_key_i <= 1'b1;
      @(posedge mclk_i);
      reset_key_i <= 1'b0;
      for (int n = 0; n < 200 && hi_o !== 4'hc; n++) @(posedge mclk_i);
      if (hi_o !== 4'hc) begin
         fail_count++;
         wrap_up();
      end
      repeat (2) @(posedge mclk_i);
      check("key indicator", 32'(ind_o), 32'hf0);
      check("key split", 32'(hi_o), 32'hc);
      check("key keeps port", 32'(cw), 32'h91);
   endtask
   task automatic t_unmapped;
      logic [31:0] r;
      logic e;
      apb(1'b0, 8'h10, 32'h0, r, e);
      check("unmapped error", 32'(e), 32'h1);
   endtask
   initial begin
      t_reset();
      t_init();
      t_outputs();
      t_switches();
      t_refuse();
      t_freeze();
      t_key();
      t_unmapped();
      wrap_up();
   end
endmodule
`default_nettype wire
